// ==== common/spcb_pkg.sv ====
// offsets, field positions, reset values and encodings of the serial port
package spcb_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CON1   = 4'h4;
  localparam logic [3:0] OFF_CON2   = 4'h8;
  localparam logic [3:0] OFF_DATA   = 4'hC;
  // status word fields
  localparam int ST_EN       = 15;
  localparam int ST_CNT_LO   = 8;
  localparam int ST_SR_EMPTY = 7;
  localparam int ST_OVF      = 6;
  localparam int ST_RX_EMPTY = 5;
  localparam int ST_ISEL_LO  = 2;
  localparam int ST_TBF      = 1;
  localparam int ST_RBF      = 0;
  // control one fields
  localparam int C1_CLK_DIS  = 12;
  localparam int C1_DO_DIS   = 11;
  localparam int C1_WIDE     = 10;
  localparam int C1_SMP      = 9;
  localparam int C1_CKE      = 8;
  localparam int C1_SLAVE_SELECT_ENABLE     = 7;
  localparam int C1_CKP      = 6;
  localparam int C1_MST      = 5;
  localparam int C1_SEC_LO   = 2;
  localparam int C1_PRI_LO   = 0;
  localparam logic [15:0] C1_MASK = 16'h1FFF;
  // control two fields
  localparam int C2_FRM      = 15;
  localparam int C2_FSD      = 14;
  localparam int C2_FPOL     = 13;
  localparam int C2_FE       = 1;
  localparam int C2_BEN      = 0;
  localparam logic [15:0] C2_MASK = 16'hE003;
  // reset values
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;
  localparam logic [2:0]  ISEL_RST = 3'h0;
  // buffer sizes
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
  localparam int DATA_W     = 16;
  localparam logic [3:0] RX_HIGH_LEVEL = 4'h6;
  // bus answer phases: read data capture, then the phase in which waitrequest drops
  localparam logic [1:0] BUS_CAPTURE = 2'h1;
  localparam logic [1:0] BUS_TAKE    = 2'h2;
  // clock divider ratios
  localparam logic [6:0] PRI_DIV_1  = 7'h01;
  localparam logic [6:0] PRI_DIV_4  = 7'h04;
  localparam logic [6:0] PRI_DIV_16 = 7'h10;
  localparam logic [6:0] PRI_DIV_64 = 7'h40;
  localparam logic [3:0] SEC_BASE   = 4'h8;
  localparam logic [9:0] MIN_RATIO  = 10'h002;
  // buffer condition selections
  localparam logic [2:0] SEL_TX_FULL  = 3'h7;
  localparam logic [2:0] SEL_TX_LAST  = 3'h6;
  localparam logic [2:0] SEL_TX_DONE  = 3'h5;
  localparam logic [2:0] SEL_TX_SPOT  = 3'h4;
  localparam logic [2:0] SEL_RX_FULL  = 3'h3;
  localparam logic [2:0] SEL_RX_HIGH  = 3'h2;
  localparam logic [2:0] SEL_RX_AVAIL = 3'h1;
  localparam logic [2:0] SEL_RX_EMPTY = 3'h0;
  // transfer engine states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FETCH = 5'h02,
    ST_LOAD  = 5'h04,
    ST_PRE   = 5'h08,
    ST_RUN   = 5'h10
  } spcb_state_e;
endpackage

// ==== verilog/spcb_mem.sv ====
// small word memory with registered read data
`timescale 1ns/1ps
module spcb_mem #(
  parameter int W  = 16,
  parameter int AW = 3
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  // storage and output register
  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [W-1:0]              q;
  } spcb_mem_s;

  spcb_mem_s r;
  spcb_mem_s n;

  // write a word and read the addressed word
  always_comb begin
    n = r;
    n.q = r.mem[rd_addr];
    if (wr_en) begin
      n.mem[wr_addr] = wr_data;
    end
  end

  // register the whole state
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data = r.q;
endmodule

// ==== verilog/spcb_port.sv ====
// serial port with control registers, buffers and transfer engine
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module spcb_port #(
  parameter int DEPTH = spcb_pkg::FIFO_DEPTH,
  parameter int AW    = spcb_pkg::FIFO_AW
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // avalon-mm register slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // serial clock pin
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  // serial data pins
  input  wire logic        serial_data_in_pin,
  output logic             serial_data_out_pin,
  output logic             serial_data_out_pin_oe,
  // select and frame sync pin
  input  wire logic        slave_select_pin_n_in,
  output logic             slave_select_pin_out,
  output logic             slave_select_pin_oe,
  // selected buffer condition
  output logic             buffer_condition
);
  // all registered state
  typedef struct packed {
    logic [1:0]            ph;     // bus answer phase
    logic [15:0]           rdata;  // captured read word
    logic [15:0]           con1;   // control one
    logic [15:0]           con2;   // control two
    logic                  en;     // module enable
    logic [2:0]            isel;   // buffer condition select
    logic                  ovf;    // receive overflow flag
    logic [AW-1:0]         txw;    // tx write pointer
    logic [AW-1:0]         txr;    // tx read pointer
    logic [AW-1:0]         rxw;    // rx write pointer
    logic [AW-1:0]         rxr;    // rx read pointer
    logic [AW:0]           txc;    // tx words held
    logic [AW:0]           rxc;    // rx words unread
    spcb_pkg::spcb_state_e st;     // engine state
    logic [15:0]           sr;     // shift register
    logic [4:0]            bitn;   // bits done in word
    logic [9:0]            cnt;    // cycle in bit window
    logic                  skip;   // lead-in window or edge
    logic                  sck;    // clock pin level
    logic                  sdo;    // data pin level
    logic                  fs;     // frame sync pin level
    logic                  cond;   // buffer condition
    logic [2:0]            sck_q;  // clock pin synchroniser
    logic [1:0]            ss_q;   // select pin synchroniser
    logic [1:0]            sdi_q;  // data pin synchroniser
  } spcb_regs_s;

  spcb_regs_s r;
  spcb_regs_s n;

  // divider ratio from primary and secondary codes
  function automatic logic [9:0] spcb_ratio(input logic [1:0] pri,
                                            input logic [2:0] sec);
    logic [6:0] p;
    logic [3:0] s;
    case (pri)
      2'h3:    p = spcb_pkg::PRI_DIV_1;
      2'h2:    p = spcb_pkg::PRI_DIV_4;
      2'h1:    p = spcb_pkg::PRI_DIV_16;
      default: p = spcb_pkg::PRI_DIV_64;
    endcase
    s = spcb_pkg::SEC_BASE - {1'h0, sec};
    spcb_ratio = 10'(p) * 10'(s);
  endfunction

  // byte lane merge for a control write
  function automatic logic [15:0] spcb_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0]  be,
                                             input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    spcb_merge = v & mask;
  endfunction

  // first bit to send for the current width
  function automatic logic spcb_msb(input logic [15:0] sr,
                                    input logic wide);
    spcb_msb = wide ? sr[15] : sr[7];
  endfunction

  // decoded controls
  logic        master;
  logic        framed;
  logic        fdir;
  logic        fpol;
  logic        fedge;
  logic        wide;
  logic        cke_eff;
  logic        act;
  logic [AW:0] cap;
  logic [9:0]  raw_ratio;
  logic [9:0]  ratio;
  logic [9:0]  half;
  logic [4:0]  nbits;
  // bus and buffer strobes
  logic        bus_req;
  logic        bus_take;
  logic        dat_wr;
  logic        dat_rd;
  logic        tx_push;
  logic        rx_pop;
  logic        tx_pop;
  logic        rx_push;
  logic [15:0] rx_wdata;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [15:0] stat;
  logic [15:0] rd_mux;
  // synchronised slave clock edges
  logic        s_chg;
  logic        s_lead;
  logic        s_trail;
  logic        s_chg_edge;
  logic        s_smp_edge;
  logic        ss_act;
  logic        fs_seen;
  logic        gate;
  logic        win_end;
  logic        smp_now;

  assign master    = r.con1[spcb_pkg::C1_MST];
  assign framed    = r.con2[spcb_pkg::C2_FRM];
  assign fdir      = r.con2[spcb_pkg::C2_FSD];
  assign fpol      = r.con2[spcb_pkg::C2_FPOL];
  assign fedge     = r.con2[spcb_pkg::C2_FE];
  assign wide      = r.con1[spcb_pkg::C1_WIDE];
  assign cke_eff   = r.con1[spcb_pkg::C1_CKE] & ~framed;
  assign act       = ~r.con1[spcb_pkg::C1_CKP];
  // one slot in single mode, the whole fifo in buffer mode
  assign cap = r.con2[spcb_pkg::C2_BEN] ? (AW+1)'(DEPTH)
                                        : (AW+1)'(1);
  assign raw_ratio = spcb_ratio(r.con1[spcb_pkg::C1_PRI_LO +: 2],
                                r.con1[spcb_pkg::C1_SEC_LO +: 3]);
  // a one to one ratio cannot make two edges, so it runs at two
  assign ratio   = (raw_ratio < spcb_pkg::MIN_RATIO) ? spcb_pkg::MIN_RATIO
                                                     : raw_ratio;
  assign half    = ratio >> 1;
  assign nbits   = wide ? 5'h10 : 5'h08;
  assign win_end = (r.cnt == ratio - 10'h001);
  // sampling point of a master bit window
  assign smp_now = r.con1[spcb_pkg::C1_SMP] ? win_end
                                            : (r.cnt == half);

  // bus decode, data location shared by both directions
  assign bus_req  = read | write;
  assign bus_take = bus_req & (r.ph == spcb_pkg::BUS_TAKE);
  assign dat_wr   = bus_take & write & (address == spcb_pkg::OFF_DATA)
                    & (|byteenable[1:0]);
  assign dat_rd   = bus_take & read & (address == spcb_pkg::OFF_DATA);
  assign tx_push  = dat_wr & r.en & (r.txc < cap);
  assign rx_pop   = dat_rd & (r.rxc != '0);

  // slave edges from the second and third synchroniser stages
  assign s_chg      = r.sck_q[1] ^ r.sck_q[2];
  assign s_lead     = s_chg & (r.sck_q[1] == act);
  assign s_trail    = s_chg & (r.sck_q[1] != act);
  assign s_chg_edge = cke_eff ? s_trail : s_lead;
  assign s_smp_edge = cke_eff ? s_lead : s_trail;
  assign ss_act     = ~r.ss_q[1];
  assign fs_seen    = (r.ss_q[1] == fpol);
  // select pin gates a slave only when enabled and unframed
  assign gate = framed | ~r.con1[spcb_pkg::C1_SLAVE_SELECT_ENABLE] | ss_act;

  // next state of bus, registers, buffers and engine
  always_comb begin
    n        = r;
    tx_pop   = 1'h0;
    rx_push  = 1'h0;
    rx_wdata = 16'h0000;
    // status word as software sees it
    stat = 16'h0000;
    stat[spcb_pkg::ST_EN]       = r.en;
    stat[spcb_pkg::ST_CNT_LO +: 3] =
      master ? ((r.txc > (AW+1)'(7)) ? 3'h7 : 3'(r.txc))
             : ((r.rxc > (AW+1)'(7)) ? 3'h7 : 3'(r.rxc));
    stat[spcb_pkg::ST_SR_EMPTY] = (r.st == spcb_pkg::ST_IDLE);
    stat[spcb_pkg::ST_OVF]      = r.ovf;
    stat[spcb_pkg::ST_RX_EMPTY] = (r.rxc == '0);
    stat[spcb_pkg::ST_ISEL_LO +: 3] = r.isel;
    stat[spcb_pkg::ST_TBF]      = (r.txc >= cap);
    stat[spcb_pkg::ST_RBF]      = (r.rxc >= cap);
    // read data multiplexer, unmapped offsets read zero
    case (address)
      spcb_pkg::OFF_STATUS: rd_mux = stat;
      spcb_pkg::OFF_CON1:   rd_mux = r.con1;
      spcb_pkg::OFF_CON2:   rd_mux = r.con2;
      spcb_pkg::OFF_DATA:   rd_mux = rx_q;
      default:              rd_mux = 16'h0000;
    endcase
    // bus answer phases, write commits in the take phase
    if (!bus_req || r.ph == spcb_pkg::BUS_TAKE) begin
      n.ph = 2'h0;
    end else begin
      n.ph = r.ph + 2'h1;
    end
    if (bus_req && r.ph == spcb_pkg::BUS_CAPTURE) begin
      n.rdata = rd_mux;
    end
    if (bus_take && write) begin
      case (address)
        spcb_pkg::OFF_STATUS: begin
          if (byteenable[1]) begin
            n.en = writedata[spcb_pkg::ST_EN];
          end
          if (byteenable[0]) begin
            n.isel = writedata[spcb_pkg::ST_ISEL_LO +: 3];
            if (!writedata[spcb_pkg::ST_OVF]) begin
              n.ovf = 1'h0;
            end
          end
        end
        spcb_pkg::OFF_CON1: begin
          n.con1 = spcb_merge(r.con1, writedata[15:0], byteenable[1:0],
                              spcb_pkg::C1_MASK);
        end
        spcb_pkg::OFF_CON2: begin
          n.con2 = spcb_merge(r.con2, writedata[15:0], byteenable[1:0],
                              spcb_pkg::C2_MASK);
        end
        default: begin
          // data pushes through tx_push, others are ignored
        end
      endcase
    end
    // pin synchronisers
    n.sck_q = {r.sck_q[1:0], serial_clock_pin_in};
    n.ss_q  = {r.ss_q[0], slave_select_pin_n_in};
    n.sdi_q = {r.sdi_q[0], serial_data_in_pin};
    // transfer engine
    case (r.st)
      spcb_pkg::ST_IDLE: begin
        // a stopped master clock holds the word back
        if (r.en && r.txc != '0 &&
            !(master && r.con1[spcb_pkg::C1_CLK_DIS])) begin
          n.st = spcb_pkg::ST_FETCH;
        end
      end
      spcb_pkg::ST_FETCH: begin
        // memory read data settles for the head word
        n.st = spcb_pkg::ST_LOAD;
      end
      spcb_pkg::ST_LOAD: begin
        // head word into the shift register frees a slot
        n.sr   = tx_q;
        tx_pop = 1'h1;
        n.bitn = 5'h00;
        n.cnt  = 10'h000;
        n.skip = 1'h0;
        if (!master && cke_eff) begin
          n.sdo = spcb_msb(tx_q, wide);
        end
        if (framed && (fdir || !master)) begin
          n.st = spcb_pkg::ST_PRE;
        end else begin
          n.st   = spcb_pkg::ST_RUN;
          n.skip = framed & ~fedge;
        end
      end
      spcb_pkg::ST_PRE: begin
        if (fdir) begin
          // wait for the incoming sync pulse
          if (fs_seen) begin
            n.st   = spcb_pkg::ST_RUN;
            n.skip = ~fedge;
          end
        end else if (s_lead) begin
          // slave frame master holds the pulse to the first clock
          n.sdo = spcb_msb(r.sr, wide);
          n.st  = spcb_pkg::ST_RUN;
        end
      end
      spcb_pkg::ST_RUN: begin
        if (master) begin
          // bit windows of ratio cycles
          n.cnt = win_end ? 10'h000 : r.cnt + 10'h001;
          n.sck = ((r.cnt < half) ^ cke_eff) ? act : ~act;
          if (!r.skip) begin
            if (r.cnt == 10'h000) begin
              n.sdo = spcb_msb(r.sr, wide);
            end
            if (smp_now) begin
              n.sr = {r.sr[14:0], r.sdi_q[1]};
            end
          end
          if (win_end) begin
            if (r.skip) begin
              n.skip = 1'h0;
            end else begin
              n.bitn = r.bitn + 5'h01;
              if (r.bitn == nbits - 5'h01) begin
                rx_push = 1'h1;
              end
            end
          end
        end else if (gate) begin
          // slave follows the outside clock, sample phase unused
          if (s_chg_edge && !r.skip) begin
            n.sdo = spcb_msb(r.sr, wide);
          end
          if (s_smp_edge) begin
            if (r.skip) begin
              n.skip = 1'h0;
            end else begin
              n.sr   = {r.sr[14:0], r.sdi_q[1]};
              n.bitn = r.bitn + 5'h01;
              if (r.bitn == nbits - 5'h01) begin
                rx_push = 1'h1;
              end
            end
          end
        end
      end
      default: begin
        n.st = spcb_pkg::ST_IDLE;
      end
    endcase
    // finished word into the receive side or dropped on overflow
    if (rx_push) begin
      n.st     = spcb_pkg::ST_IDLE;
      n.sck    = ~act;
      rx_wdata = wide ? n.sr : {8'h00, n.sr[7:0]};
      if (r.rxc >= cap) begin
        rx_push = 1'h0;
        n.ovf   = 1'h1;
      end
    end
    if (r.st != spcb_pkg::ST_RUN) begin
      n.sck = ~act;
    end
    // pointers and counts, set and clear in one cycle both count
    if (tx_push) begin
      n.txw = r.txw + 1'h1;
    end
    if (tx_pop) begin
      n.txr = r.txr + 1'h1;
    end
    if (rx_push) begin
      n.rxw = r.rxw + 1'h1;
    end
    if (rx_pop) begin
      n.rxr = r.rxr + 1'h1;
    end
    n.txc = r.txc + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    n.rxc = r.rxc + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    // a disabled port stops and empties its buffers
    if (!r.en) begin
      n.st  = spcb_pkg::ST_IDLE;
      n.txw = '0;
      n.txr = '0;
      n.rxw = '0;
      n.rxr = '0;
      n.txc = '0;
      n.rxc = '0;
    end
    // frame sync pulse once per word, one bit window from a master, held to the first clock from a slave
    n.fs = (framed && !fdir &&
            ((master && n.st == spcb_pkg::ST_RUN &&
              (n.skip || (n.bitn == 5'h00 && fedge))) ||
             (!master && n.st == spcb_pkg::ST_PRE)))
           ? fpol : ~fpol;
    // buffer condition chosen by the select field in buffer mode, rx full in single mode
    if (!r.con2[spcb_pkg::C2_BEN]) begin
      n.cond = (n.rxc >= cap);
    end else begin
      case (r.isel)
        spcb_pkg::SEL_TX_FULL:  n.cond = (n.txc >= cap);
        spcb_pkg::SEL_TX_LAST:  n.cond = (n.txc == '0) &&
                                         (n.st != spcb_pkg::ST_IDLE);
        spcb_pkg::SEL_TX_DONE:  n.cond = (n.txc == '0) &&
                                         (n.st == spcb_pkg::ST_IDLE);
        spcb_pkg::SEL_TX_SPOT:  n.cond = (n.txc < cap);
        spcb_pkg::SEL_RX_FULL:  n.cond = (n.rxc >= cap);
        spcb_pkg::SEL_RX_HIGH:  n.cond = ({1'h0, n.rxc} >=
                                          spcb_pkg::RX_HIGH_LEVEL);
        spcb_pkg::SEL_RX_AVAIL: n.cond = (n.rxc != '0);
        default:                n.cond = (n.rxc == '0);
      endcase
    end
  end

  // register the whole state
  always_ff @(posedge mclk) begin
    if (rst) begin
      r       <= '0;
      r.con1  <= spcb_pkg::CON1_RST;
      r.con2  <= spcb_pkg::CON2_RST;
      r.isel  <= spcb_pkg::ISEL_RST;
      r.st    <= spcb_pkg::ST_IDLE;
      r.fs    <= 1'h1;
      r.cond  <= 1'h1;
      r.ss_q  <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // transmit buffer storage
  spcb_mem #(.W(spcb_pkg::DATA_W), .AW(AW)) u_tx_mem (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (tx_push),
    .wr_addr (r.txw),
    .wr_data (writedata[15:0]),
    .rd_addr (r.txr),
    .rd_data (tx_q)
  );

  // receive buffer storage
  spcb_mem #(.W(spcb_pkg::DATA_W), .AW(AW)) u_rx_mem (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (rx_push),
    .wr_addr (r.rxw),
    .wr_data (rx_wdata),
    .rd_addr (r.rxr),
    .rd_data (rx_q)
  );

  // bus answer and pins
  assign readdata    = {16'h0000, r.rdata};
  assign waitrequest = bus_req & (r.ph != spcb_pkg::BUS_TAKE);
  assign serial_clock_pin_out   = r.sck;
  assign serial_clock_pin_oe    = r.en & master &
                                  ~r.con1[spcb_pkg::C1_CLK_DIS];
  assign serial_data_out_pin    = r.sdo;
  assign serial_data_out_pin_oe = r.en &
                                  ~r.con1[spcb_pkg::C1_DO_DIS];
  assign slave_select_pin_out   = r.fs;
  assign slave_select_pin_oe    = r.en & framed & ~fdir;
  assign buffer_condition       = r.cond;
endmodule

// ==== verification/spcb_port_asserts.sv ====
// port checker of the serial port block
`timescale 1ns/1ps
module spcb_port_asserts #(
  parameter int DEPTH = 8
) (
  // clock, reset and bus
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pin enables
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_out_pin_oe,
  input wire logic        slave_select_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic hi_wr;  // upper lane write taken
  logic lo_wr;  // lower lane write taken
  assign hi_wr = write & ~waitrequest & byteenable[1];
  assign lo_wr = write & ~waitrequest & byteenable[0];
  chk_two_waits: assert property ($rose(read | write) |->
    waitrequest [*2] ##1 !waitrequest) else $error("bus answer late");
  chk_upper_zero: assert property (read && !waitrequest |->
    readdata[31:16] == 16'h0000) else $error("upper half set");
  chk_unmapped_zero: assert property (read && !waitrequest &&
    address[1:0] != 2'h0 |-> readdata == 32'h0) else $error("bad read");
  chk_reset_pins: assert property ($fell(rst) |->
    !(serial_clock_pin_oe | serial_data_out_pin_oe | slave_select_pin_oe))
    else $error("pin driven after reset");
  chk_sdo_off: assert property (hi_wr && address == 4'h4 &&
    writedata[11] |=> !serial_data_out_pin_oe) else $error("sdo driven");
  chk_sck_off: assert property (hi_wr && address == 4'h4 &&
    writedata[12] |=> !serial_clock_pin_oe) else $error("sck driven");
  chk_slave_sck: assert property (lo_wr && address == 4'h4 &&
    !writedata[5] |=> !serial_clock_pin_oe) else $error("slave drives sck");
  chk_frame_off: assert property (hi_wr && address == 4'h8 &&
    !writedata[15] |=> !slave_select_pin_oe) else $error("sync driven");
  chk_enable_off: assert property (hi_wr && address == 4'h0 &&
    !writedata[15] |=> !serial_data_out_pin_oe && !serial_clock_pin_oe)
    else $error("disabled port drives pins");
  cover property (read && !waitrequest);
  cover property (serial_clock_pin_oe);
  cover property (hi_wr && address == 4'h0);
endmodule
bind spcb_port spcb_port_asserts #(.DEPTH(DEPTH)) u_spcb_port_asserts (
  .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_out_pin_oe(serial_data_out_pin_oe),
  .slave_select_pin_oe(slave_select_pin_oe));

// ==== verification/spcb_slave_model.sv ====
// far-side serial slave answering one byte each frame
`timescale 1ns/1ps
module spcb_slave_model (
  // serial clock and data from the port
  input  wire logic       sck,
  input  wire logic       mosi,
  // byte to answer with
  input  wire logic [7:0] reply,
  // data back to the port and byte taken
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] tx = 8'h00;  // bits still to send
  logic [2:0] n = 3'h0;    // bits done in this byte
  initial miso = 1'h1;
  // idle low clock: new bit on the rising edge, msb first
  always @(posedge sck) begin
    miso <= (n == 3'h0) ? reply[7] : tx[7];
    tx   <= (n == 3'h0) ? {reply[6:0], 1'h0} : {tx[6:0], 1'h0};
  end
  // take the master bit at the falling edge, mid window
  always @(negedge sck) begin
    got <= {got[6:0], mosi};
    n   <= n + 3'h1;
  end
endmodule

// ==== verification/spcb_port_tb.sv ====
// bench for the serial port block
`timescale 1ns/1ps
module spcb_port_tb;
  typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e;} spcb_row_s;
  logic        mclk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
  logic [3:0]  address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic        waitrequest, sck_o, sck_oe, sdo, sdo_oe, ss_o, ss_oe, cond;
  logic        sck, ss, miso;
  logic [7:0]  got;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  spcb_row_s   rows [6] = '{'{4'h4, 16'hFFFF, 16'h1FFF},
    '{4'h8, 16'hFFFF, 16'hE003}, '{4'h4, 16'h0000, 16'h0000},
    '{4'h8, 16'h0000, 16'h0000}, '{4'h2, 16'hFFFF, 16'h0000},
    '{4'h4, 16'h003A, 16'h003A}};
  assign sck = sck_oe ? sck_o : 1'h0;  // pull-down on the clock pin
  assign ss = ss_oe ? ss_o : 1'h1;     // pull-up on the select pin
  spcb_port u_spcb_port (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(miso),
    .serial_data_out_pin(sdo), .serial_data_out_pin_oe(sdo_oe),
    .slave_select_pin_n_in(ss), .slave_select_pin_out(ss_o),
    .slave_select_pin_oe(ss_oe), .buffer_condition(cond));
  spcb_slave_model u_spcb_slave_model (.sck(sck), .mosi(sdo),
    .reply(8'hA5), .miso(miso), .got(got));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic bus(input logic [3:0] a, input logic wr, logic [15:0] d);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0, d};
    // hold the request until the edge that sees waitrequest low
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'h0);
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [15:0] d);
    int t;
    t = 0;
    bus(4'hC, 1'h1, d);
    repeat (4) @(posedge mclk);
    // poll the status until the engine is idle again
    do begin
      bus(4'h0, 1'h0, 16'h0);
      t++;
    end while (rd[7] !== 1'h1 && t < 200);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    bus(4'h4, 1'h0, 16'h0);
    check("con1 reset", rd[15:0], 16'h0000);
    bus(4'h0, 1'h0, 16'h0);
    check("full flags", {14'h0, rd[1:0]}, 16'h0000);
    check("sync idle", {15'h0, ss_o}, 16'h0001);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'h1, rows[i].w);
      bus(rows[i].a, 1'h0, 16'h0);
      check("register", rd[15:0], rows[i].e);
    end
    bus(4'h0, 1'h1, 16'h8000);
    xfer(16'h1234);
    check("sent byte", {8'h0, got}, 16'h0034);
    check("sck idle", {15'h0, sck}, 16'h0000);
    bus(4'h0, 1'h0, 16'h0);
    check("rx full", {15'h0, rd[0]}, 16'h0001);
    check("rx cond", {15'h0, cond}, 16'h0001);
    bus(4'hC, 1'h0, 16'h0);
    check("rx data", rd[15:0], 16'h00A5);
    bus(4'h0, 1'h0, 16'h0);
    check("rx read", {15'h0, rd[0]}, 16'h0000);
    xfer(16'h0055);
    xfer(16'h0056);
    check("overflow", {15'h0, rd[6]}, 16'h0001);
    // framed, sync pulse driven by the port
    bus(4'h8, 1'h1, 16'h8000);
    check("sync drive", {15'h0, ss_oe}, 16'h0001);
    bus(4'h8, 1'h1, 16'h0001);
    // enable kept, condition select on tx full
    bus(4'h0, 1'h1, 16'h801C);
    bus(4'h4, 1'h1, 16'h103A);
    check("sck off", {15'h0, sck_oe}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      bus(4'hC, 1'h1, 16'(i));
    end
    bus(4'h0, 1'h0, 16'h0);
    check("fifo full", {13'h0, rd[10:8]}, 16'h0007);
    check("tx full", {15'h0, rd[1]}, 16'h0001);
    check("tx cond", {15'h0, cond}, 16'h0001);
    bus(4'h4, 1'h1, 16'h003A);
    for (int i = 0; i < 20 && rd[1] !== 1'h0; i++) begin
      bus(4'h0, 1'h0, 16'h0);
    end
    check("tx slot", {15'h0, rd[1]}, 16'h0000);
    bus(4'h0, 1'h1, 16'h0000);
    check("sdo off", {15'h0, sdo_oe}, 16'h0000);
    finish_test();
  end
endmodule
